/* gg_host_model.sv */
`timescale 1ns/1ps
// ****
// Bus master.
// ****
module gg_host_model (
  // Bus wires.
  input  wire logic sdaIn,
  output logic      sclClk,
  output logic      sdaPull
);
  logic linkClk = 1'b0;
  // Link clock runs free; SCL moves only inside frames.
  always #16 linkClk = ~linkClk;
  // Bus idles released.
  initial begin
    sclClk = 1'b1;
    sdaPull = 1'b0;
  end
  // Waits a few link cycles.
  task automatic hp(input int n = 8);
    repeat (n) @(posedge linkClk);
  endtask : hp
  task automatic wake;
    sdaPull = 1'b1;
    hp();
    sdaPull = 1'b0;
  endtask : wake
  task automatic start;
    hp(2);
    sdaPull = 1'b0;
    hp();
    sclClk = 1'b1;
    hp();
    sdaPull = 1'b1;
    hp();
    sclClk = 1'b0;
  endtask : start
  task automatic stop;
    hp(2);
    sdaPull = 1'b1;
    hp();
    sclClk = 1'b1;
    hp();
    sdaPull = 1'b0;
    hp();
  endtask : stop
  task automatic bits(input logic [8:0] o, output logic [8:0] i);
    for (int k = 8; k >= 0; k--) begin
      hp(2);
      sdaPull = ~o[k];
      hp();
      sclClk = 1'b1;
      hp();
      i[k] = sdaIn;
      sclClk = 1'b0;
    end
    hp(2);
    sdaPull = 1'b0;
  endtask : bits
endmodule : gg_host_model

/* gg_i2c_register_port.sv */
// Notes on behaviour
// RULE_01: Answer only to seven-bit address 0001011.
// RULE_02: Read: address, command, restart, low, high, CRC.
// RULE_03: Write carries CRC; bad or missing discards word.
// RULE_04: CRC-8 ATM over all bytes except CRC.
// RULE_05: Sleeping host pulls SDA low before traffic.
// RULE_06: Wake lapses after hold time without traffic.
// RULE_07: Operational mode accepts traffic without wake.
// RULE_08: Shared bus: host selects operational mode first.
// RULE_09: Sample voltage after power-on delay, initialise charge.
// RULE_10: Magic at 0x04 initialises from maximum voltage.
// RULE_11: Magic at 0x07 initialises from present voltage.
// RULE_12: Host forces initialisation only at light load.
// RULE_13: Temperature in decikelvin; host writes range checked.
// RULE_14: Thermistor mode: power switch, sense, load temperature.
// RULE_15: Host mode: host rewrites temperature on change.
// RULE_16: Command 0x09 reads cell voltage in millivolts.
// RULE_17: Direction register limits reported charge movement.
// RULE_18: Charge reported as percent and per mille.
// RULE_19: Charge alarm threshold at 0x13, reset eight.
// RULE_20: Voltage alarm threshold at 0x14, reset zero.
// RULE_21: Power mode register selects operational or sleep.
// RULE_22: Thermistor beta word at 0x06, reset 0x0D34.
// RULE_23: Ready within wake delay; hold at least 500ms.
// RULE_24: Alarm low while value under enabled threshold.
// RULE_25: Sleep keeps bus only; gauging suspended. The code still updates alarmOutN and the maximum voltage in sleep.
// RULE_26: Unknown commands and read-only writes do nothing.
`timescale 1ns/1ps
`include "gg_map.svh"
module gg_i2c_register_port #(
  parameter int unsigned WAKE_READY_CYC  = (`GG_WAKE_READY_US * `GG_CLK_KHZ) / 1000,
  parameter int unsigned WAKE_HOLD_CYC   = `GG_WAKE_HOLD_MS * `GG_CLK_KHZ,
  parameter int unsigned POR_SAMPLE_CYC  = `GG_POR_SAMPLE_MS * `GG_CLK_KHZ,
  parameter int unsigned TEMP_PERIOD_CYC = `GG_TEMP_PERIOD_MS * `GG_CLK_KHZ,
  parameter int unsigned TEMP_ON_CYC     = (`GG_TEMP_ON_US * `GG_CLK_KHZ) / 1000,
  parameter logic [15:0] CHIP_VERSION    = 16'h0001,  // Arbitrary value.
  parameter logic [15:0] PROFILE_ID      = 16'h0001   // Arbitrary value.
) (
  // Clocks and reset.
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        sclClk,
  // Two-wire data pin.
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  // Measurement and gauging engine.
  input  wire logic [15:0] cellVoltageMv,
  input  wire logic [15:0] thermistorSenseInput,
  input  wire logic [15:0] gaugePermille,
  output logic             gaugeEnable,
  output logic             socInitReq,
  output logic [15:0]      socInitVoltageMv,
  // Alarm and thermistor supply.
  output logic             alarmOutN,
  output logic             thermistorPowerSwitch
);
  localparam int TW = 26;

  // ************************************************************
  // Link domain: bits sampled on the bus clock.
  // ************************************************************
  logic       linkBit_ff;
  logic [1:0] linkPtr_ff;

  // Each rising bus clock takes one bit and steps a gray pointer.
  always_ff @(posedge sclClk or negedge rst_b) begin
    if (!rst_b) begin
      linkBit_ff <= 1'b0;
      linkPtr_ff <= 2'b00;
    end else begin
      linkBit_ff <= sdaIn;
      linkPtr_ff <= {linkPtr_ff[0], ~linkPtr_ff[1]};
    end
  end

  // ************************************************************
  // Pin and pointer synchronisers.
  // ************************************************************
  logic       sclS1_ff, sclS2_ff, sclD_ff, sdaS1_ff, sdaS2_ff, sdaD_ff;
  logic [1:0] ptrS1_ff, ptrS2_ff, ptrSeen_ff;

  // Two flops per input, then one more stage for edge detection.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      {sclS1_ff, sclS2_ff, sclD_ff} <= 3'b111;
      {sdaS1_ff, sdaS2_ff, sdaD_ff} <= 3'b111;
      {ptrS1_ff, ptrS2_ff, ptrSeen_ff} <= 6'h00;
    end else begin
      {sclS1_ff, sclS2_ff, sclD_ff} <= {sclClk, sclS1_ff, sclS2_ff};
      {sdaS1_ff, sdaS2_ff, sdaD_ff} <= {sdaIn, sdaS1_ff, sdaS2_ff};
      {ptrS1_ff, ptrS2_ff, ptrSeen_ff} <= {linkPtr_ff, ptrS1_ff, ptrS2_ff};
    end
  end

  // Bus events; the link bit is stable while the pointer is new.
  wire startEv = sclS2_ff & sclD_ff & sdaD_ff & ~sdaS2_ff;
  wire stopEv  = sclS2_ff & sclD_ff & ~sdaD_ff & sdaS2_ff;
  wire sclFall = sclD_ff & ~sclS2_ff;
  wire sdaFall = sdaD_ff & ~sdaS2_ff;
  wire bitEv   = ptrS2_ff != ptrSeen_ff;

  // ************************************************************
  // Register bank storage.
  // ************************************************************
  logic [15:0] beta_ff, temp_ff, dir_ff, apa_ff, apt_ff, prof_ff;
  logic [15:0] lowChg_ff, lowVolt_ff, pwr_ff, tsrc_ff, reportPm_ff;
  logic [15:0] maxV_ff, socInitV_ff;
  logic        socInit_ff, porDone_ff, alarmN_ff, thermSw_ff, gaugeEn_ff;
  logic [TW-1:0] porCnt_ff, tempCnt_ff;

  // ************************************************************
  // Wake condition.
  // ************************************************************
  gg_pkg::gg_wake_t wake_ff;
  logic [TW-1:0]    wakeCnt_ff;
  logic             inFrame_ff;
  wire opMode  = pwr_ff == `GG_PM_OP;
  // RULE_07 operational bypasses wake.
  wire accept  = opMode | (wake_ff == gg_pkg::WK_ON);
  wire holdEnd = wakeCnt_ff == TW'(WAKE_HOLD_CYC - 1);

  // RULE_05 SDA fall wakes.
  // RULE_06 hold timers lapse.
  // RULE_23 ready and hold counts.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_ff    <= gg_pkg::WK_SLEEP;
      wakeCnt_ff <= '0;
    end else begin
      unique case (wake_ff)
        gg_pkg::WK_SLEEP: begin
          wakeCnt_ff <= '0;
          if (sdaFall && !opMode) begin
            wake_ff <= gg_pkg::WK_WAIT;
          end
        end
        gg_pkg::WK_WAIT: begin
          wakeCnt_ff <= wakeCnt_ff + 1'b1;
          if (wakeCnt_ff == TW'(WAKE_READY_CYC - 1)) begin
            wake_ff <= gg_pkg::WK_ON;
          end
        end
        gg_pkg::WK_ON: begin
          if (stopEv || inFrame_ff) begin
            wakeCnt_ff <= '0;
          end else if (holdEnd) begin
            wake_ff    <= gg_pkg::WK_SLEEP;
            wakeCnt_ff <= '0;
          end else begin
            wakeCnt_ff <= wakeCnt_ff + 1'b1;
          end
        end
        default: begin
          wake_ff    <= gg_pkg::WK_SLEEP;
          wakeCnt_ff <= '0;
        end
      endcase
    end
  end

  // ************************************************************
  // Byte engine.
  // ************************************************************
  gg_pkg::gg_xfer_t xfer_ff;
  logic [3:0]  bitCnt_ff;
  logic [2:0]  byteNo_ff;
  logic [1:0]  txIdx_ff;
  logic [7:0]  rxByte_ff, txShift_ff, crc_ff, cmd_ff, dataLo_ff, dataHi_ff;
  logic [15:0] rdWord_ff;
  logic        sdaOe_ff, mAck_ff, wrCommit_ff, frameOk_ff;
  wire  [15:0] readMux;

  // RULE_04 CRC-8 ATM step.
  function automatic logic [7:0] crcStep(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ `GG_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crcStep

  // Decoded byte-level conditions.
  wire addrHit   = (rxByte_ff[7:1] == `GG_ADDR) && (frameOk_ff || opMode);
  wire ackPoint  = sclFall && (bitCnt_ff == 4'h8);
  wire endPoint  = sclFall && (bitCnt_ff == 4'h9);
  wire midPoint  = sclFall && (bitCnt_ff != 4'h0) && (bitCnt_ff < 4'h8);
  wire sendNext  = (txIdx_ff == 2'b00) || mAck_ff;
  wire [7:0] txByte = (txIdx_ff == 2'b00) ? rdWord_ff[7:0]  :
                      (txIdx_ff == 2'b01) ? rdWord_ff[15:8] :
                      (txIdx_ff == 2'b10) ? crc_ff : 8'hff;
  wire [7:0] crcRx  = crcStep(crc_ff, rxByte_ff);
  wire [7:0] crcTx  = crcStep(crc_ff, txByte);

  // Start, stop, bit counting and the per-byte decisions.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      xfer_ff <= gg_pkg::XF_IDLE;
      {bitCnt_ff, byteNo_ff, txIdx_ff} <= '0;
      {rxByte_ff, txShift_ff, crc_ff, cmd_ff, dataLo_ff, dataHi_ff} <= '0;
      rdWord_ff <= '0;
      {sdaOe_ff, mAck_ff, wrCommit_ff, inFrame_ff, frameOk_ff} <= '0;
    end else begin
      wrCommit_ff <= 1'b0;
      if (startEv) begin
        // RULE_04 seed, kept across restart.
        if (!inFrame_ff) begin
          crc_ff    <= '0;
          byteNo_ff <= '0;
        end
        xfer_ff    <= gg_pkg::XF_ADDR;
        inFrame_ff <= 1'b1;
        frameOk_ff <= accept;
        bitCnt_ff  <= '0;
        txIdx_ff   <= '0;
        sdaOe_ff   <= 1'b0;
      end else if (stopEv) begin
        xfer_ff    <= gg_pkg::XF_IDLE;
        inFrame_ff <= 1'b0;
        sdaOe_ff   <= 1'b0;
      end else if (bitEv) begin
        bitCnt_ff <= bitCnt_ff + 1'b1;
        if (bitCnt_ff < 4'h8) begin
          rxByte_ff <= {rxByte_ff[6:0], linkBit_ff};
        end else begin
          mAck_ff <= ~linkBit_ff;
        end
      end else if (ackPoint) begin
        sdaOe_ff <= 1'b0;
        if (xfer_ff == gg_pkg::XF_ADDR) begin
          // RULE_01 address match.
          if (addrHit) begin
            sdaOe_ff  <= 1'b1;
            crc_ff    <= crcRx;
            rdWord_ff <= readMux;
            xfer_ff   <= rxByte_ff[0] ? gg_pkg::XF_RD : gg_pkg::XF_WR;
          end else begin
            xfer_ff <= gg_pkg::XF_IDLE;
          end
        end else if (xfer_ff == gg_pkg::XF_WR) begin
          sdaOe_ff <= 1'b1;
          if (byteNo_ff != 3'h4) begin
            byteNo_ff <= byteNo_ff + 1'b1;
          end
          if (byteNo_ff < 3'h3) begin
            crc_ff <= crcRx;
          end
          if (byteNo_ff == 3'h0) begin
            cmd_ff <= rxByte_ff;
          end
          if (byteNo_ff == 3'h1) begin
            dataLo_ff <= rxByte_ff;
          end
          if (byteNo_ff == 3'h2) begin
            dataHi_ff <= rxByte_ff;
          end
          // RULE_03 commit only on matching CRC.
          if (byteNo_ff == 3'h3) begin
            wrCommit_ff <= rxByte_ff == crc_ff;
          end
        end
      end else if (endPoint) begin
        bitCnt_ff <= '0;
        sdaOe_ff  <= 1'b0;
        // RULE_02 low, high, CRC until NACK.
        if (xfer_ff == gg_pkg::XF_RD) begin
          if (sendNext) begin
            sdaOe_ff   <= ~txByte[7];
            txShift_ff <= {txByte[6:0], 1'b1};
            txIdx_ff   <= txIdx_ff + 1'b1;
            if (txIdx_ff < 2'b10) begin
              crc_ff <= crcTx;
            end
          end else begin
            xfer_ff <= gg_pkg::XF_IDLE;
          end
        end
      end else if (midPoint && (xfer_ff == gg_pkg::XF_RD)) begin
        sdaOe_ff   <= ~txShift_ff[7];
        txShift_ff <= {txShift_ff[6:0], 1'b1};
      end
    end
  end

  // ************************************************************
  // Register decode and effects.
  // ************************************************************
  wire [15:0] wrWord  = {dataHi_ff, dataLo_ff};
  wire        magic   = wrWord == `GG_MAGIC;
  wire        wrHit   = wrCommit_ff;
  wire        thermOn = tsrc_ff == `GG_TS_THERM;
  wire [15:0] pct     = 16'(reportPm_ff / `GG_PCT_DIV);
  wire [15:0] gaugeC  = (gaugePermille > `GG_PML_FULL) ? `GG_PML_FULL : gaugePermille;
  wire        tempOk  = (wrWord >= `GG_TEMP_MIN) && (wrWord <= `GG_TEMP_MAX);
  wire        dirOk   = (wrWord == `GG_DIR_AUTO) || (wrWord == `GG_DIR_CHG) || (wrWord == `GG_DIR_DIS);
  wire        pwrOk   = (wrWord == `GG_PM_OP) || (wrWord == `GG_PM_SLEEP);
  wire        tsrcOk  = (wrWord == `GG_TS_HOST) || (wrWord == `GG_TS_THERM);
  wire        initMax = wrHit && (cmd_ff == `GG_CMD_INIT_MAX) && magic;
  wire        initNow = wrHit && (cmd_ff == `GG_CMD_INIT_NOW) && magic;
  wire        porHit  = !porDone_ff && (porCnt_ff == TW'(POR_SAMPLE_CYC - 1));
  // RULE_17 direction limits movement.
  wire        pmMove  = (dir_ff == `GG_DIR_AUTO) ||
                        ((dir_ff == `GG_DIR_CHG) && (gaugeC > reportPm_ff)) ||
                        ((dir_ff == `GG_DIR_DIS) && (gaugeC < reportPm_ff));
  wire        tempEnd = thermSw_ff && (tempCnt_ff == TW'(TEMP_ON_CYC - 1));

  // RULE_16 voltage read.
  // RULE_18 percent and per mille.
  // RULE_26 unknown codes read zero.
  assign readMux =
    (cmd_ff == `GG_CMD_BETA)     ? beta_ff       :
    (cmd_ff == `GG_CMD_TEMP)     ? temp_ff       :
    (cmd_ff == `GG_CMD_VOLT)     ? cellVoltageMv :
    (cmd_ff == `GG_CMD_DIR)      ? dir_ff        :
    (cmd_ff == `GG_CMD_APA)      ? apa_ff        :
    (cmd_ff == `GG_CMD_APT)      ? apt_ff        :
    (cmd_ff == `GG_CMD_PCT)      ? pct           :
    (cmd_ff == `GG_CMD_PML)      ? reportPm_ff   :
    (cmd_ff == `GG_CMD_VER)      ? CHIP_VERSION  :
    (cmd_ff == `GG_CMD_PROF)     ? prof_ff       :
    (cmd_ff == `GG_CMD_LOW_CHG)  ? lowChg_ff     :
    (cmd_ff == `GG_CMD_LOW_VOLT) ? lowVolt_ff    :
    (cmd_ff == `GG_CMD_PWR)      ? pwr_ff        :
    (cmd_ff == `GG_CMD_TSRC)     ? tsrc_ff       :
    (cmd_ff == `GG_CMD_PROF_ID)  ? PROFILE_ID    : `GG_RST_ZERO;

  // Host writes to the writable words; other codes change nothing.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      beta_ff    <= `GG_RST_BETA;
      dir_ff     <= `GG_DIR_AUTO;
      apa_ff     <= `GG_RST_ZERO;
      apt_ff     <= `GG_RST_APT;
      prof_ff    <= `GG_RST_ZERO;
      lowChg_ff  <= `GG_RST_LOW_CHG;
      lowVolt_ff <= `GG_RST_ZERO;
      pwr_ff     <= `GG_PM_SLEEP;
      tsrc_ff    <= `GG_TS_HOST;
    end else if (wrHit) begin
      // RULE_22 beta word.
      if (cmd_ff == `GG_CMD_BETA) beta_ff <= wrWord;
      if (cmd_ff == `GG_CMD_DIR && dirOk) dir_ff <= wrWord;
      if (cmd_ff == `GG_CMD_APA) apa_ff <= wrWord;
      if (cmd_ff == `GG_CMD_APT) apt_ff <= wrWord;
      if (cmd_ff == `GG_CMD_PROF) prof_ff <= {15'h0000, wrWord[0]};
      // RULE_19 charge threshold.
      if (cmd_ff == `GG_CMD_LOW_CHG) lowChg_ff <= wrWord;
      // RULE_20 voltage threshold.
      if (cmd_ff == `GG_CMD_LOW_VOLT) lowVolt_ff <= wrWord;
      // RULE_21 power mode select.
      if (cmd_ff == `GG_CMD_PWR && pwrOk) pwr_ff <= wrWord;
      if (cmd_ff == `GG_CMD_TSRC && tsrcOk) tsrc_ff <= wrWord;
    end
  end

  // RULE_13 host temperature in range.
  // RULE_14 thermistor result loads.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      temp_ff <= `GG_RST_TEMP;
    end else if (tempEnd && thermOn) begin
      temp_ff <= thermistorSenseInput;
    end else if (wrHit && (cmd_ff == `GG_CMD_TEMP) && !thermOn && tempOk) begin
      temp_ff <= wrWord;
    end
  end

  // RULE_14 switch powered only while measuring.
  // RULE_25 no measuring in sleep.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      thermSw_ff <= 1'b0;
      tempCnt_ff <= '0;
    end else if (!(thermOn && opMode) || tempEnd) begin
      thermSw_ff <= 1'b0;
      tempCnt_ff <= '0;
    end else if (!thermSw_ff && (tempCnt_ff == TW'(TEMP_PERIOD_CYC - 1))) begin
      thermSw_ff <= 1'b1;
      tempCnt_ff <= '0;
    end else begin
      tempCnt_ff <= tempCnt_ff + 1'b1;
    end
  end

  // RULE_09 power-on sample.
  // RULE_10 maximum since initialisation.
  // RULE_11 present voltage, next cycle.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      porCnt_ff   <= '0;
      porDone_ff  <= 1'b0;
      maxV_ff     <= `GG_RST_ZERO;
      socInit_ff  <= 1'b0;
      socInitV_ff <= `GG_RST_ZERO;
    end else begin
      socInit_ff <= porHit | initMax | initNow;
      if (!porDone_ff) begin
        porCnt_ff <= porCnt_ff + 1'b1;
      end
      if (porHit) begin
        porDone_ff  <= 1'b1;
        maxV_ff     <= cellVoltageMv;
        socInitV_ff <= cellVoltageMv;
      end else if (initMax) begin
        socInitV_ff <= (cellVoltageMv > maxV_ff) ? cellVoltageMv : maxV_ff;
      end else if (initNow) begin
        socInitV_ff <= cellVoltageMv;
      end else if (porDone_ff && (cellVoltageMv > maxV_ff)) begin
        maxV_ff <= cellVoltageMv;
      end
    end
  end

  // RULE_17 tracked charge report.
  // RULE_24 alarm level.
  // RULE_25 gauging only when operational.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reportPm_ff <= `GG_RST_ZERO;
      alarmN_ff   <= 1'b1;
      gaugeEn_ff  <= 1'b0;
    end else begin
      gaugeEn_ff <= opMode;
      if (socInit_ff || (gaugeEn_ff && pmMove)) begin
        reportPm_ff <= gaugeC;
      end
      alarmN_ff <= !(((lowChg_ff != `GG_RST_ZERO) && (pct < lowChg_ff)) ||
                     ((lowVolt_ff != `GG_RST_ZERO) && (cellVoltageMv < lowVolt_ff)));
    end
  end

  // Outputs straight from flops; the data pin only ever pulls low.
  logic sdaOut_ff;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) sdaOut_ff <= 1'b0;
    else sdaOut_ff <= 1'b0;
  end
  assign sdaOut                = sdaOut_ff;
  assign sdaOe                 = sdaOe_ff;
  assign gaugeEnable           = gaugeEn_ff;
  assign socInitReq            = socInit_ff;
  assign socInitVoltageMv      = socInitV_ff;
  assign alarmOutN             = alarmN_ff;
  assign thermistorPowerSwitch = thermSw_ff;

  // ************************************************************
  // Assertions.
  // ************************************************************
  property p_addrNack;
    @(posedge core_clk) disable iff (!rst_b)
    (ackPoint && xfer_ff == gg_pkg::XF_ADDR && rxByte_ff[7:1] != `GG_ADDR) |=> !sdaOe_ff;
  endproperty
  a_addrNack: assert property (p_addrNack) else $error("foreign address acknowledged"); // RULE_01

  property p_nackEnds;
    @(posedge core_clk) disable iff (!rst_b)
    (endPoint && xfer_ff == gg_pkg::XF_RD && txIdx_ff != 2'b00 && !mAck_ff)
      |=> (xfer_ff == gg_pkg::XF_IDLE) && !sdaOe_ff;
  endproperty
  a_nackEnds: assert property (p_nackEnds) else $error("read went on after NACK"); // RULE_02

  property p_badCrc;
    @(posedge core_clk) disable iff (!rst_b)
    (ackPoint && xfer_ff == gg_pkg::XF_WR && byteNo_ff == 3'h3 && rxByte_ff != crc_ff)
      |=> !wrCommit_ff ##1 $stable(beta_ff);
  endproperty
  a_badCrc: assert property (p_badCrc) else $error("word kept despite bad CRC"); // RULE_03

  property p_crcSeed;
    @(posedge core_clk) disable iff (!rst_b)
    (startEv && !inFrame_ff) |=> (crc_ff == 8'h00) && (byteNo_ff == 3'h0);
  endproperty
  a_crcSeed: assert property (p_crcSeed) else $error("CRC not seeded at start"); // RULE_04

  property p_holdLapse;
    @(posedge core_clk) disable iff (!rst_b)
    (wake_ff == gg_pkg::WK_ON && holdEnd && !inFrame_ff && !stopEv) |=> wake_ff == gg_pkg::WK_SLEEP;
  endproperty
  a_holdLapse: assert property (p_holdLapse) else $error("wake did not lapse"); // RULE_06

  property p_opAck;
    @(posedge core_clk) disable iff (!rst_b)
    (opMode && ackPoint && xfer_ff == gg_pkg::XF_ADDR && rxByte_ff[7:1] == `GG_ADDR) |=> sdaOe_ff;
  endproperty
  a_opAck: assert property (p_opAck) else $error("operational mode refused address"); // RULE_07

  property p_initNow;
    @(posedge core_clk) disable iff (!rst_b)
    initNow |=> socInitReq && (socInitVoltageMv == $past(cellVoltageMv));
  endproperty
  a_initNow: assert property (p_initNow) else $error("present-voltage init missed"); // RULE_11

  property p_chargeMode;
    @(posedge core_clk) disable iff (!rst_b)
    (dir_ff == `GG_DIR_CHG && !socInit_ff) |=> reportPm_ff >= $past(reportPm_ff);
  endproperty
  a_chargeMode: assert property (p_chargeMode) else $error("charge report fell"); // RULE_17

  property p_voltAlarm;
    @(posedge core_clk) disable iff (!rst_b)
    (lowVolt_ff != `GG_RST_ZERO && cellVoltageMv < lowVolt_ff) ##1 $stable(cellVoltageMv) |-> !alarmOutN;
  endproperty
  a_voltAlarm: assert property (p_voltAlarm) else $error("voltage alarm not raised"); // RULE_24

endmodule : gg_i2c_register_port

/* gg_i2c_register_port_tb.sv */
`timescale 1ns/1ps
// ****
// Bench.
// ****
module gg_i2c_register_port_tb;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        sclClk, sdaPull, sdaOut, sdaOe, gaugeEnable, socInitReq, alarmOutN, thermistor_power_switch;
  logic [15:0] cellVoltageMv = 16'h0ec2;
  logic [15:0] thermistorSenseInput = 16'h0ba6;
  logic [15:0] gaugePermille = 16'h0032;
  logic [15:0] socInitVoltageMv, d;
  logic        sdaIn, a;
  int          mismatches = 0;
  int          check_count = 0;
  // Pulled-up wire: low when either side pulls.
  assign sdaIn = ~(sdaOe | sdaPull);
  // Core clock.
  always #10 core_clk = ~core_clk;
  gg_host_model u_gg_host_model (.sdaIn(sdaIn), .sclClk(sclClk), .sdaPull(sdaPull));
  gg_i2c_register_port #(.WAKE_READY_CYC(20), .WAKE_HOLD_CYC(200), .POR_SAMPLE_CYC(50), .TEMP_PERIOD_CYC(100),
    .TEMP_ON_CYC(10)) u_gg_i2c_register_port (.core_clk(core_clk), .rst_b(rst_b), .sclClk(sclClk), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .cellVoltageMv(cellVoltageMv), .thermistorSenseInput(thermistorSenseInput),
    .gaugePermille(gaugePermille), .gaugeEnable(gaugeEnable), .socInitReq(socInitReq),
    .socInitVoltageMv(socInitVoltageMv), .alarmOutN(alarmOutN), .thermistorPowerSwitch(thermistor_power_switch));
  // Checksum step, polynomial 0x07.
  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] x;
    x = c ^ b;
    repeat (8) x = x[7] ? ((x << 1) ^ 8'h07) : (x << 1);
    return x;
  endfunction : crc
  // Compares and counts.
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Sends one byte and returns the ack.
  task automatic xb(input logic [7:0] b, output logic k);
    logic [8:0] r;
    u_gg_host_model.bits({b, 1'b1}, r);
    k = ~r[0];
  endtask : xb
  // Word write, checksum spoiled on request.
  task automatic wr(input logic [7:0] cmd, input logic [15:0] w, input logic bad);
    logic [7:0] c;
    c = crc(crc(crc(crc(8'h00, 8'h16), cmd), w[7:0]), w[15:8]);
    u_gg_host_model.start();
    xb(8'h16, a);
    xb(cmd, a);
    xb(w[7:0], a);
    xb(w[15:8], a);
    xb(c ^ {8{bad}}, a);
    u_gg_host_model.stop();
  endtask : wr
  // Word read with checksum compare.
  task automatic rd(input logic [7:0] cmd);
    logic [8:0] r;
    u_gg_host_model.start();
    xb(8'h16, a);
    xb(cmd, a);
    u_gg_host_model.start();
    xb(8'h17, a);
    u_gg_host_model.bits(9'h1fe, r);
    d[7:0] = r[8:1];
    u_gg_host_model.bits(9'h1fe, r);
    d[15:8] = r[8:1];
    u_gg_host_model.bits(9'h1ff, r);
    u_gg_host_model.stop();
    chk("crc", {8'h00, r[8:1]}, {8'h00, crc(crc(crc(crc(crc(8'h00, 8'h16), cmd), 8'h17), d[7:0]), d[15:8])});
  endtask : rd
  // Prints the verdict and stops.
  task automatic end_of_test;
    if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // Wake, reset value, then operational mode.
  task automatic t_wake;
    u_gg_host_model.wake();
    repeat (30) @(posedge core_clk);
    rd(8'h06);
    chk("beta", d, 16'h0d34);
    wr(8'h15, 16'h0001, 1'b0);
    chk("gauge", {15'h0, gaugeEnable}, 16'h0001);
  endtask : t_wake
  // Address filter and traffic without wake.
  task automatic t_addr;
    repeat (300) @(posedge core_clk);
    u_gg_host_model.start();
    xb(8'h18, a);
    u_gg_host_model.stop();
    chk("nack", {15'h0, a}, 16'h0000);
    rd(8'h09);
    chk("volt", d, 16'h0ec2);
  endtask : t_addr
  // Bad checksum discards, good one commits.
  task automatic t_crc;
    wr(8'h13, 16'h0020, 1'b1);
    rd(8'h13);
    chk("thr", d, 16'h0008);
    wr(8'h13, 16'h0020, 1'b0);
    rd(8'h13);
    chk("thr", d, 16'h0020);
    wr(8'h08, 16'h0aac, 1'b0);
    wr(8'h08, 16'h0d05, 1'b0);
    rd(8'h08);
    chk("temp", d, 16'h0aac);
  endtask : t_crc
  // Present and maximum voltage initialisation.
  task automatic t_init;
    @(posedge core_clk) cellVoltageMv <= 16'h0e10;
    wr(8'h07, 16'haa55, 1'b0);
    chk("now", socInitVoltageMv, 16'h0e10);
    chk("alarm", {15'h0, alarmOutN}, 16'h0000);
    wr(8'h14, 16'h0f00, 1'b0);
    wr(8'h13, 16'h0000, 1'b0);
    chk("valarm", {15'h0, alarmOutN}, 16'h0000);
    rd(8'h0d);
    chk("pct", d, 16'h0005);
    wr(8'h04, 16'haa55, 1'b0);
    chk("max", socInitVoltageMv, 16'h0ec2);
    wr(8'h0a, 16'h0001, 1'b0);
    @(posedge core_clk) gaugePermille <= 16'h0014;
    rd(8'h0d);
    chk("dir", d, 16'h0005);
    wr(8'h16, 16'h0001, 1'b0);
    @(posedge thermistor_power_switch);
    rd(8'h08);
    chk("therm", d, 16'h0ba6);
  endtask : t_init
  // Sleep mode; the wake lapses after the hold time.
  task automatic t_sleep;
    wr(8'h15, 16'h0002, 1'b0);
    chk("gauge", {15'h0, gaugeEnable}, 16'h0000);
    repeat (300) @(posedge core_clk);
    u_gg_host_model.start();
    xb(8'h16, a);
    u_gg_host_model.stop();
    chk("lapse", {15'h0, a}, 16'h0000);
  endtask : t_sleep
  // Main sequence.
  initial begin
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (60) @(posedge core_clk);
    t_wake();
    t_addr();
    t_crc();
    t_init();
    t_sleep();
    end_of_test();
  end
  // Watchdog.
  initial begin
    #1000000;
    mismatches++;
    end_of_test();
  end
endmodule : gg_i2c_register_port_tb

/* gg_map.svh */
`ifndef GG_MAP_SVH
`define GG_MAP_SVH
// Bus address and command codes.
`define GG_ADDR           7'h0b
`define GG_CMD_INIT_MAX   8'h04
`define GG_CMD_BETA       8'h06
`define GG_CMD_INIT_NOW   8'h07
`define GG_CMD_TEMP       8'h08
`define GG_CMD_VOLT       8'h09
`define GG_CMD_DIR        8'h0a
`define GG_CMD_APA        8'h0b
`define GG_CMD_APT        8'h0c
`define GG_CMD_PCT        8'h0d
`define GG_CMD_PML        8'h0f
`define GG_CMD_VER        8'h11
`define GG_CMD_PROF       8'h12
`define GG_CMD_LOW_CHG    8'h13
`define GG_CMD_LOW_VOLT   8'h14
`define GG_CMD_PWR        8'h15
`define GG_CMD_TSRC       8'h16
`define GG_CMD_PROF_ID    8'h1a
// Field values and reset values.
`define GG_MAGIC          16'haa55
`define GG_TEMP_MIN       16'h09e4
`define GG_TEMP_MAX       16'h0d04
`define GG_PM_OP          16'h0001
`define GG_PM_SLEEP       16'h0002
`define GG_TS_HOST        16'h0000
`define GG_TS_THERM       16'h0001
`define GG_DIR_AUTO       16'h0000
`define GG_DIR_CHG        16'h0001
`define GG_DIR_DIS        16'hffff
`define GG_PML_FULL       16'h03e8
`define GG_PCT_DIV        16'h000a
`define GG_RST_BETA       16'h0d34
`define GG_RST_TEMP       16'h0ba6
`define GG_RST_APT        16'h001e
`define GG_RST_LOW_CHG    16'h0008
`define GG_RST_ZERO       16'h0000
`define GG_CRC_POLY       8'h07
// Times in their own units and the clock rate.
`define GG_CLK_KHZ        50000
`define GG_WAKE_READY_US  400
`define GG_WAKE_HOLD_MS   500
`define GG_POR_SAMPLE_MS  10
`define GG_TEMP_PERIOD_MS 1000
`define GG_TEMP_ON_US     100
`endif

/* gg_pkg.sv */
package gg_pkg;
  // Wake condition of the bus port.
  typedef enum logic [1:0] {
    WK_SLEEP = 2'b00,
    WK_WAIT  = 2'b01,
    WK_ON    = 2'b10
  } gg_wake_t;
  // Byte transfer phase of the bus port.
  typedef enum logic [1:0] {
    XF_IDLE = 2'b00,
    XF_ADDR = 2'b01,
    XF_WR   = 2'b10,
    XF_RD   = 2'b11
  } gg_xfer_t;
endpackage : gg_pkg
